// >>> eph_cyc_if.sv
// Request and answer of one memory bus cycle
`timescale 1ns/10ps
interface eph_cyc_if;
    logic        req;
    logic        wr;
    logic [12:0] addr;
    logic [7:0]  wdata;
    logic        done;
    logic [7:0]  rdata;

    modport ctl (output req, output wr, output addr, output wdata, input done, input rdata);
    modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// >>> eph_cycle.sv
// One read or write cycle on the memory pins
`timescale 1ns/10ps
module eph_cycle
    import eph_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Cycle request
    eph_cyc_if.eng                 cyc,
    // Memory pins
    output      logic [ADDR_W-1:0] mem_addr,
    output      logic              mem_ce_n,
    output      logic              mem_oe_n,
    output      logic              mem_we_n,
    output      logic [DATA_W-1:0] mem_dq_out,
    output      logic              mem_dq_oe_n,
    input  wire logic [DATA_W-1:0] mem_dq_in
);

    eph_cyc_e          state;
    logic [7:0]        cnt;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic              cnt_zero;

    assign cnt_zero = (cnt == 8'h00);

    // Data pins come from outside the clock domain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_s1 <= 8'h00;
            dq_s2 <= 8'h00;
        end else begin
            dq_s1 <= mem_dq_in;
            dq_s2 <= dq_s1;
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= CY_IDLE;
            cnt   <= 8'h00;
        end else begin
            unique case (state)
                CY_IDLE: begin
                    if (cyc.req) begin
                        state <= cyc.wr ? CY_WPULSE : CY_RACC;
                        cnt   <= cyc.wr ? 8'(CYC_WP - 1) : 8'(CYC_ACC - 1);
                    end
                end
                CY_WPULSE: begin
                    cnt <= cnt - 8'h01;
                    if (cnt_zero) begin
                        state <= CY_WREC;
                        cnt   <= 8'(CYC_WPH - 1);
                    end
                end
                CY_RACC: begin
                    cnt <= cnt - 8'h01;
                    if (cnt_zero) begin
                        state <= CY_RREC;
                        cnt   <= 8'(CYC_OEHP - 1);
                    end
                end
                CY_WREC, CY_RREC: begin
                    cnt <= cnt - 8'h01;
                    if (cnt_zero) begin
                        state <= CY_IDLE;
                    end
                end
                default: begin
                    state <= CY_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Pin drive
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_addr    <= 13'h0000;
            mem_ce_n    <= 1'b1;
            mem_oe_n    <= 1'b0;
            mem_we_n    <= 1'b1;
            mem_dq_out  <= 8'h00;
            mem_dq_oe_n <= 1'b1;
        end else begin
            if (state == CY_IDLE && cyc.req) begin
                mem_addr <= cyc.addr;
                mem_ce_n <= 1'b0;
                if (cyc.wr) begin
                    // OE rises only together with the write strobes
                    // OE with strobes
                    mem_we_n    <= 1'b0;
                    mem_oe_n    <= 1'b1;
                    mem_dq_out  <= cyc.wdata;
                    mem_dq_oe_n <= 1'b0;
                end
            end else if (cnt_zero && (state == CY_WPULSE || state == CY_RACC)) begin
                // CE high also ends any device drive before our next write
                // OE stays low between reads: CE alone frames each poll
                mem_ce_n    <= 1'b1;
                mem_we_n    <= 1'b1;
                mem_oe_n    <= 1'b0;
                mem_dq_oe_n <= 1'b1;
            end else if (cnt_zero && state == CY_RREC) begin
                mem_oe_n <= 1'b0;
            end
        end
    end

    // Answer of the cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc.rdata <= 8'h00;
            cyc.done  <= 1'b0;
        end else begin
            cyc.done <= cnt_zero && (state == CY_WREC || state == CY_RREC);
            if (cnt_zero && state == CY_RACC) begin
                cyc.rdata <= dq_s2;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_oe_only_in_pulse;
        @(posedge clk) disable iff (!rst_n)
        mem_oe_n |-> (!mem_we_n && !mem_ce_n);
    endproperty
    a_oe_only_in_pulse: assert property (p_oe_only_in_pulse)
        else $error("OE high outside write pulse");

    property p_no_contention;
        @(posedge clk) disable iff (!rst_n)
        !mem_dq_oe_n |-> (mem_oe_n && !mem_we_n);
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("Host drives data while device may drive");

    property p_wp_width;
        @(posedge clk) disable iff (!rst_n)
        $fell(mem_we_n) |-> (!mem_we_n)[*8];
    endproperty
    a_wp_width: assert property (p_wp_width)
        else $error("Write pulse too short");

endmodule // eph_cycle

// >>> eph_host.sv
// Host controller for a parallel page-write EEPROM with unlock sequence
`timescale 1ns/10ps
// How it works
// - Every write command is opened by the three unlock writes.
// - Zero to sixty-four data bytes follow the unlock writes.
// - Unlock writes use the prescribed addresses on the whole address bus.
// - Page address bits stay identical for every byte of one load.
// - Output enable goes high only while write strobe and chip select are low.
// - Toggle polling repeats reads at one constant address.
// - Toggle completion judged by change between reads, never by level.
// - Each next byte is written inside the byte-load window.
module eph_host
    import eph_pkg::*;
#(
    parameter int unsigned       BLC_CYC  = CYC_BLC,
    parameter int unsigned       WC_CYC   = CYC_WC,
    parameter logic [ADDR_W-1:0] U_ADDR0  = UNL_ADDR0,
    parameter logic [ADDR_W-1:0] U_ADDR1  = UNL_ADDR1,
    parameter logic [ADDR_W-1:0] U_ADDR2  = UNL_ADDR2,
    parameter logic [DATA_W-1:0] U_DATA0  = UNL_DATA0,
    parameter logic [DATA_W-1:0] U_DATA1  = UNL_DATA1,
    parameter logic [DATA_W-1:0] U_DATA2  = UNL_DATA2
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Command
    input  wire logic              cmd_valid,
    output      logic              cmd_ready,
    input  wire logic              cmd_write,
    input  wire logic              cmd_toggle_poll,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    // Write data stream
    input  wire logic              wr_valid,
    output      logic              wr_ready,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_last,
    // Read result and status
    output      logic              rd_valid,
    output      logic [DATA_W-1:0] rd_data,
    output      logic              done,
    output      logic              err_timeout,
    output      logic              load_cut,
    output      logic              busy,
    // Memory pins
    output      logic [ADDR_W-1:0] mem_addr,
    output      logic              mem_ce_n,
    output      logic              mem_oe_n,
    output      logic              mem_we_n,
    output      logic [DATA_W-1:0] mem_dq_out,
    output      logic              mem_dq_oe_n,
    input  wire logic [DATA_W-1:0] mem_dq_in
);

    if (BLC_CYC <= LOAD_MARGIN || WC_CYC < 1) begin : g_chk
        $error("Window counts too small for load margin");
    end

    eph_cyc_if cyc ();

    eph_state_e              state;
    eph_state_e              next_state;
    logic [1:0]              step;
    logic [1:0]              unl_seen;
    logic [ADDR_W-PAGE_LSB-1:0] page;
    logic [PAGE_LSB-1:0]     offset;
    logic [6:0]              count;
    logic                    end_load;
    logic [ADDR_W-1:0]       last_addr;
    logic [DATA_W-1:0]       last_data;
    logic                    toggle_mode;
    logic                    prev6;
    logic                    have_prev;
    logic                    inflight;
    logic [31:0]             blc_cnt;
    logic [31:0]             wc_cnt;
    logic                    take_cmd;
    logic                    take_wr;
    logic                    bus_free;
    logic                    blc_over;
    logic                    wc_over;
    logic                    poll_hit;

    function automatic logic [ADDR_W+DATA_W-1:0] unlock_word(input logic [1:0] s);
        unique case (s)
            2'd0:    unlock_word = {U_ADDR0, U_DATA0};
            2'd1:    unlock_word = {U_ADDR1, U_DATA1};
            default: unlock_word = {U_ADDR2, U_DATA2};
        endcase
    endfunction

    assign take_cmd = cmd_valid && cmd_ready;
    assign take_wr  = wr_valid && wr_ready;
    assign bus_free = !inflight && !cyc.req;
    assign blc_over = (state == ST_LOAD) && bus_free && !take_wr
                      && (blc_cnt >= 32'(BLC_CYC - LOAD_MARGIN));
    assign wc_over  = (state == ST_POLL) && bus_free && (wc_cnt >= 32'(WC_CYC));
    assign poll_hit = toggle_mode
                      ? (have_prev && (cyc.rdata[POLL_BIT_TGL] == prev6))
                      : (cyc.rdata[POLL_BIT_CMP] == last_data[POLL_BIT_CMP]);

    // ************************************************************
    // Command sequencing
    // ************************************************************
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (take_cmd) begin
                    next_state = cmd_write ? ST_UNLOCK : ST_READ;
                end
            end
            ST_UNLOCK: begin
                if (cyc.done && step == 2'd2) begin
                    next_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if ((cyc.done && end_load) || blc_over) begin
                    next_state = ST_POLL;
                end
            end
            ST_POLL: begin
                if ((cyc.done && poll_hit) || wc_over) begin
                    next_state = ST_IDLE;
                end
            end
            ST_READ: begin
                if (cyc.done) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= ST_IDLE;
            cmd_ready <= 1'b1;
            busy      <= 1'b0;
        end else begin
            state     <= next_state;
            cmd_ready <= (next_state == ST_IDLE);
            busy      <= (next_state != ST_IDLE);
        end
    end

    // Unlock step and load bookkeeping
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step        <= 2'd0;
            unl_seen    <= 2'd0;
            page        <= '0;
            offset      <= '0;
            count       <= 7'd0;
            end_load    <= 1'b0;
            toggle_mode <= 1'b0;
            last_addr   <= 13'h0000;
            last_data   <= 8'h00;
        end else begin
            if (take_cmd) begin
                step        <= 2'd0;
                unl_seen    <= 2'd0;
                page        <= cmd_addr[ADDR_W-1:PAGE_LSB];
                offset      <= cmd_addr[PAGE_LSB-1:0];
                count       <= 7'd0;
                end_load    <= 1'b0;
                toggle_mode <= cmd_toggle_poll;
                last_addr   <= cmd_addr;
            end else if (state == ST_UNLOCK && cyc.done) begin
                step     <= step + 2'd1;
                unl_seen <= unl_seen + 2'd1;
            end else if (take_wr) begin
                last_addr <= {page, offset};
                last_data <= wr_data;
                offset    <= offset + 6'd1;
                count     <= count + 7'd1;
                end_load  <= wr_last || (count == 7'(PAGE_BYTES - 1));
            end else if (blc_over && count == 7'd0) begin
                // No byte stored: only the toggle bit is meaningful
                toggle_mode <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Cycle requests
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc.req   <= 1'b0;
            cyc.wr    <= 1'b0;
            cyc.addr  <= 13'h0000;
            cyc.wdata <= 8'h00;
            inflight  <= 1'b0;
        end else begin
            cyc.req <= 1'b0;
            if (cyc.req) begin
                inflight <= 1'b1;
            end else if (cyc.done) begin
                inflight <= 1'b0;
            end
            if (state == ST_UNLOCK && bus_free && !cyc.done) begin
                cyc.req                  <= 1'b1;
                cyc.wr                   <= 1'b1;
                {cyc.addr, cyc.wdata}    <= unlock_word(step);
            end else if (take_wr) begin
                cyc.req   <= 1'b1;
                cyc.wr    <= 1'b1;
                cyc.addr  <= {page, offset};
                cyc.wdata <= wr_data;
            end else if ((state == ST_POLL && !wc_over && !(cyc.done && poll_hit))
                         || state == ST_READ) begin
                if (bus_free && !cyc.done) begin
                    cyc.req  <= 1'b1;
                    cyc.wr   <= 1'b0;
                    cyc.addr <= last_addr;
                end
            end
        end
    end

    // Window and write-cycle timers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blc_cnt <= 32'd0;
            wc_cnt  <= 32'd0;
        end else begin
            blc_cnt <= (cyc.req && cyc.wr) ? 32'd0 : blc_cnt + 32'd1;
            wc_cnt  <= (state == ST_POLL) ? wc_cnt + 32'd1 : 32'd0;
        end
    end

    // ************************************************************
    // Data stream handshake and poll history
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ready  <= 1'b0;
            prev6     <= 1'b0;
            have_prev <= 1'b0;
        end else begin
            wr_ready <= (next_state == ST_LOAD) && !take_wr && !cyc.req && !end_load
                        && (!inflight || cyc.done) && (count < 7'(PAGE_BYTES));
            if (state != ST_POLL) begin
                have_prev <= 1'b0;
            end else if (cyc.done) begin
                prev6     <= cyc.rdata[POLL_BIT_TGL];
                have_prev <= 1'b1;
            end
        end
    end

    // Results
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid    <= 1'b0;
            rd_data     <= 8'h00;
            done        <= 1'b0;
            err_timeout <= 1'b0;
            load_cut    <= 1'b0;
        end else begin
            rd_valid <= (state == ST_READ) && cyc.done;
            done     <= (state != ST_IDLE) && (next_state == ST_IDLE);
            if (state == ST_READ && cyc.done) begin
                rd_data <= cyc.rdata;
            end
            if (take_cmd) begin
                err_timeout <= 1'b0;
                load_cut    <= 1'b0;
            end else begin
                err_timeout <= err_timeout || wc_over;
                load_cut    <= load_cut || blc_over;
            end
        end
    end

    eph_cycle u_cycle (
        .clk         (clk),
        .rst_n       (rst_n),
        .cyc         (cyc),
        .mem_addr    (mem_addr),
        .mem_ce_n    (mem_ce_n),
        .mem_oe_n    (mem_oe_n),
        .mem_we_n    (mem_we_n),
        .mem_dq_out  (mem_dq_out),
        .mem_dq_oe_n (mem_dq_oe_n),
        .mem_dq_in   (mem_dq_in)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    property p_unlock_first;
        @(posedge clk) disable iff (!rst_n)
        (state == ST_LOAD && cyc.req) |-> (unl_seen == 2'd3);
    endproperty
    a_unlock_first: assert property (p_unlock_first)
        else $error("Data write without full unlock");

    property p_unlock_addr;
        @(posedge clk) disable iff (!rst_n)
        (state == ST_UNLOCK && cyc.req && step == 2'd1) |-> (cyc.addr == U_ADDR1);
    endproperty
    a_unlock_addr: assert property (p_unlock_addr)
        else $error("Wrong second unlock address");

    property p_page_max;
        @(posedge clk) disable iff (!rst_n)
        (state == ST_LOAD && cyc.req) |-> (count <= 7'd64 && count != 7'd0);
    endproperty
    a_page_max: assert property (p_page_max)
        else $error("Page byte count out of range");

    property p_page_same;
        @(posedge clk) disable iff (!rst_n)
        (state == ST_LOAD && cyc.req) |-> (cyc.addr[12:6] == $past(page, 1));
    endproperty
    a_page_same: assert property (p_page_same)
        else $error("Page address moved during load");

    property p_window;
        @(posedge clk) disable iff (!rst_n)
        (state == ST_LOAD && cyc.req) |-> (blc_cnt < 32'(BLC_CYC));
    endproperty
    a_window: assert property (p_window)
        else $error("Byte issued after load window");

    property p_poll_addr;
        @(posedge clk) disable iff (!rst_n)
        (state == ST_POLL && cyc.req) |-> ($stable(last_addr) && cyc.addr == last_addr);
    endproperty
    a_poll_addr: assert property (p_poll_addr)
        else $error("Poll address changed");

    property p_toggle_two;
        @(posedge clk) disable iff (!rst_n)
        (state == ST_POLL && toggle_mode && cyc.done && next_state == ST_IDLE)
            |-> (have_prev && cyc.rdata[6] == prev6);
    endproperty
    a_toggle_two: assert property (p_toggle_two)
        else $error("Toggle completion without two equal reads");

endmodule // eph_host

// >>> eph_host_tb.sv
// Self-checking bench for the EEPROM host controller
`timescale 1ns/10ps
module eph_host_tb
    import eph_pkg::*;
    ;
    logic        clk = 0, rst_n = 0, cmd_valid = 0, cmd_write = 0, cmd_toggle_poll = 0;
    logic        wr_valid = 0, wr_last = 0;
    logic [12:0] cmd_addr = '0, mem_addr;
    logic [7:0]  wr_data = '0, rd_data, mem_dq_out, mem_dq_in;
    logic        cmd_ready, wr_ready, rd_valid, done, err_timeout, load_cut, busy;
    logic        mem_ce_n, mem_oe_n, mem_we_n, mem_dq_oe_n;
    logic [9:0]  q [$];
    logic [7:0]  em [8192];
    int          errors = 0, tests_run = 0;
    always #2.5 clk = ~clk;
    eph_host #(.BLC_CYC(200), .WC_CYC(2000)) DUT (.clk, .rst_n, .cmd_valid, .cmd_ready,
        .cmd_write, .cmd_toggle_poll, .cmd_addr, .wr_valid, .wr_ready, .wr_data, .wr_last,
        .rd_valid, .rd_data, .done, .err_timeout, .load_cut, .busy, .mem_addr, .mem_ce_n,
        .mem_oe_n, .mem_we_n, .mem_dq_out, .mem_dq_oe_n, .mem_dq_in);
    eph_mem_model MEM (.clk, .a(mem_addr), .ce_n(mem_ce_n), .oe_n(mem_oe_n),
        .we_n(mem_we_n), .dq(mem_dq_out), .dq_in(mem_dq_in));
    task automatic chk(logic [9:0] e, logic [9:0] s);
        tests_run++;
        if (e !== s) begin
            errors++;
            $display("wrong value %s expected %h seen %h", e[9] ? "flags" : "rd_data", e, s);
        end
    endtask
    task automatic give_verdict;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) begin
        #1;
        if (rd_valid === 1'b1) chk(q.pop_front(), {2'b00, rd_data});
        else if (done === 1'b1 && q.size() > 0 && q[0][9])
            chk(q.pop_front(), {1'b1, busy, 6'h00, load_cut, err_timeout});
    end
    task automatic issue(logic w, logic tg, logic [12:0] ad);
        {cmd_valid, cmd_write, cmd_toggle_poll, cmd_addr} = {1'b1, w, tg, ad};
        while (cmd_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        cmd_valid = 0;
    endtask
    task automatic wait_done;
        logic seen = 1'b0;
        repeat (20000) begin
            @(posedge clk);
            #1;
            if (done === 1'b1) begin
                seen = 1'b1;
                break;
            end
        end
        // A command that never ends is a mismatch, not a silent pass
        if (seen !== 1'b1) begin
            errors++;
            $display("wrong value done expected 1 seen 0");
        end
        @(negedge clk);
    endtask
    // Random page and offset, so loads wrap inside the page
    task automatic page(int n, logic last, logic tg);
        logic [12:0] ad;
        ad = 13'($urandom);
        q.push_back({8'h80, !last, 1'b0});
        issue(1, tg, ad);
        for (int i = 0; i < n; i++) begin
            {wr_valid, wr_data, wr_last} = {1'b1, 8'($urandom), last && i == n - 1};
            em[{ad[12:6], 6'(ad[5:0] + i)}] = wr_data;
            while (wr_ready !== 1'b1) @(negedge clk);
            @(negedge clk);
        end
        wr_valid = 0;
        wait_done;
        for (int i = 0; i < n; i++) begin
            q.push_back({2'b00, em[{ad[12:6], 6'(ad[5:0] + i)}]});
            issue(0, 0, {ad[12:6], 6'(ad[5:0] + i)});
            wait_done;
        end
    endtask
    initial begin
        void'($urandom(32'hec2e));
        repeat (8) @(negedge clk);
        rst_n = 1;
        page(3, 1, 0);
        page(64, 1, 0);
        page(1, 1, 1);
        page(2 + $urandom % 6, 1, 1);
        page(1, 0, 0);
        chk(10'h000, 10'(q.size()));
        give_verdict;
    end
    initial begin
        #400000;
        errors++;
        give_verdict;
    end
endmodule // eph_host_tb

// >>> eph_mem_model.sv
// Behavioural page-write EEPROM watched from its pins
`timescale 1ns/10ps
module eph_mem_model
    import eph_pkg::*;
#(
    parameter int WIN = 120,
    parameter int WC  = 300
) (
    // Clock and pins
    input  wire logic        clk,
    input  wire logic [12:0] a,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [7:0]  dq,
    output      logic [7:0]  dq_in
);
    logic [7:0]  mem [8192];
    logic [7:0]  ld, lv, pd;
    logic [12:0] la, pa;
    logic        load, tgl, pw, pc, po;
    int          step, nb, cnt, bsy;
    initial {load, tgl, pw, pc, po, step, nb, cnt, bsy, lv} = '0;
    function automatic logic unl(int s, logic [12:0] ad, logic [7:0] d);
        return s == 0 ? ad == UNL_ADDR0 && d == UNL_DATA0 :
               s == 1 ? ad == UNL_ADDR1 && d == UNL_DATA1 : ad == UNL_ADDR2 && d == UNL_DATA2;
    endfunction
    // Pins sampled per clock so strobe edges never race each other
    always @(posedge clk) begin
        if (load && ++cnt >= WIN) {load, bsy} = {1'b0, WC};
        if (bsy > 0) bsy--;
        if (we_n && !pw && !pc && po && bsy == 0) begin
            if (load) begin
                mem[pa] = pd;
                {la, ld, cnt} = {pa, pd, 32'd0};
                if (++nb == PAGE_BYTES) {load, bsy} = {1'b0, WC};
            end else if (unl(step, pa, pd)) step++;
            else step = 0;
            if (step == 3) {load, step, nb, cnt} = {1'b1, 96'd0};
        end
        // each read while busy flips bit six
        if (!ce_n && pc && we_n) begin
            if (load) {load, bsy} = {1'b0, WC};
            if (bsy > 0) tgl = ~tgl;
        end
        {pw, pc, po, pa, pd} = {we_n, ce_n, oe_n, a, dq};
    end
    // drive only when read, else no stale value
    always @* if (!ce_n && !oe_n && we_n) begin
        lv = mem[a];
        if (bsy > 0 && a == la) lv[7] = ~ld[7];
        if (bsy > 0) lv[6] = tgl;
        dq_in = lv;
    end else dq_in = ~lv;
endmodule // eph_mem_model

// >>> eph_pkg.sv
// Constants and types shared by the parallel EEPROM host controller
package eph_pkg;

    // ************************************************************
    // Widths and page geometry
    // ************************************************************
    localparam int ADDR_W       = 13;
    localparam int DATA_W       = 8;
    localparam int PAGE_LSB     = 6;
    localparam int PAGE_BYTES   = 64;
    localparam int POLL_BIT_CMP = 7;
    localparam int POLL_BIT_TGL = 6;
    localparam int SYNC_STAGES  = 2;

    // ************************************************************
    // Unlock command defaults, overridable at the top
    // ************************************************************
    localparam logic [12:0] UNL_ADDR0 = 13'h1555;
    localparam logic [12:0] UNL_ADDR1 = 13'h0AAA;
    localparam logic [12:0] UNL_ADDR2 = 13'h1555;
    localparam logic [7:0]  UNL_DATA0 = 8'hAA;
    localparam logic [7:0]  UNL_DATA1 = 8'h55;
    localparam logic [7:0]  UNL_DATA2 = 8'hA0;

    // ************************************************************
    // Timing, 200 MHz clock
    // ************************************************************
    localparam int CLK_NS     = 5;
    localparam int T_WP_NS    = 200;
    localparam int T_WPH_NS   = 100;
    localparam int T_ACC_NS   = 250;
    localparam int T_OEHP_NS  = 150;
    localparam int T_BLC_US   = 100;
    localparam int T_WC_MS    = 10;
    // Least times round up
    localparam int CYC_WP     = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_WPH    = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_ACC    = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
    localparam int CYC_OEHP   = (T_OEHP_NS + CLK_NS - 1) / CLK_NS;
    // Longest times round down
    localparam int CYC_BLC    = (T_BLC_US * 1000) / CLK_NS;
    localparam int CYC_WC     = (T_WC_MS * 1000000) / CLK_NS;
    localparam int LOAD_MARGIN = 64;

    // ************************************************************
    // State encodings
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_UNLOCK = 3'b001,
        ST_LOAD   = 3'b010,
        ST_POLL   = 3'b011,
        ST_READ   = 3'b100
    } eph_state_e;

    typedef enum logic [2:0] {
        CY_IDLE   = 3'b000,
        CY_WPULSE = 3'b001,
        CY_WREC   = 3'b010,
        CY_RACC   = 3'b011,
        CY_RREC   = 3'b100
    } eph_cyc_e;

endpackage
